// ---- hdl/supen_reg.sv ----
// supply output enable request register
`timescale 1ns/1ps
`default_nettype none
`include "supen_params.svh"

module supen_reg
    import supen_pkg::*;
(
    input wire logic clock,
    input wire logic rstn,
    input wire logic ce,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_rd,
    input wire logic sm_restore,
    input wire logic [10:0] hold_off,
    output logic [15:0] reg_rdata,
    output logic reg_rd_ack,
    output logic limit_switch_on_request,
    output logic linear_reg_four_on,
    output logic linear_reg_three_on,
    output logic linear_reg_two_on,
    output logic linear_reg_one_on,
    output logic switcher_six_on,
    output logic switcher_five_on,
    output logic switcher_four_on,
    output logic switcher_three_on,
    output logic switcher_two_on,
    output logic switcher_one_on,
    output logic [10:0] supply_on
);

    localparam supen_word_t IMPL = `SUPEN_IMPL_MASK;
    localparam supen_word_t DEFV = `SUPEN_RESET_VAL;
    localparam int NSUP = `SUPEN_NUM_SUPPLIES;
    localparam supen_addr_t RADDR = `SUPEN_REG_ADDR;

    // read handshake states, one-hot
    typedef enum logic [1:0] {
        SUPEN_RD_IDLE = 2'b01,
        SUPEN_RD_ACK = 2'b10
    } supen_rd_state_t;

    logic hit;
    logic wr_hit;
    supen_word_t req_w;
    supen_supply_t req_vec;
    supen_word_t rdata_r;
    supen_word_t rdata_nxt;
    supen_word_t wr_bits;
    supen_word_t rd_word;
    supen_rd_state_t rd_state_r;
    supen_rd_state_t rd_state_nxt;
    supen_supply_t req_r;
    supen_supply_t req_nxt;
    supen_supply_t on_r;
    supen_supply_t on_nxt;

    // address decode; other addresses take no writes and read zero
    always_comb begin
        hit = 1'b0;
        if (reg_addr == RADDR) begin
            hit = 1'b1;
        end
    end

    assign wr_hit = reg_wr && hit;

    // write decode: only mapped positions take data
    always_comb begin
        wr_bits = '0;
        if (wr_hit) begin
            wr_bits = IMPL;
        end
    end

    // request storage, one cell per bit position
    genvar gi;
    generate
        for (gi = 0; gi < 16; gi = gi + 1) begin : g_bit
            supen_req_cell #(
                .IMPLEMENTED(IMPL[gi]),
                .DEFAULT_VAL(DEFV[gi])
            ) u_cell (
                .clock(clock),
                .rstn(rstn),
                .ce(ce),
                .restore(sm_restore),
                .wr(wr_bits[gi]),
                .wbit(reg_wdata[gi]),
                .q(req_w[gi])
            );
        end
    endgenerate

    // gather request bits into supply order
    always_comb begin
        req_vec = '0;
        req_vec[SUPEN_IDX_LIMIT] = req_w[`SUPEN_BIT_LIMIT_SW];
        req_vec[SUPEN_IDX_LREG4] = req_w[`SUPEN_BIT_LREG4];
        req_vec[SUPEN_IDX_LREG3] = req_w[`SUPEN_BIT_LREG3];
        req_vec[SUPEN_IDX_LREG2] = req_w[`SUPEN_BIT_LREG2];
        req_vec[SUPEN_IDX_LREG1] = req_w[`SUPEN_BIT_LREG1];
        req_vec[SUPEN_IDX_SW6] = req_w[`SUPEN_BIT_SW6];
        req_vec[SUPEN_IDX_SW5] = req_w[`SUPEN_BIT_SW5];
        req_vec[SUPEN_IDX_SW4] = req_w[`SUPEN_BIT_SW4];
        req_vec[SUPEN_IDX_SW3] = req_w[`SUPEN_BIT_SW3];
        req_vec[SUPEN_IDX_SW2] = req_w[`SUPEN_BIT_SW2];
        req_vec[SUPEN_IDX_SW1] = req_w[`SUPEN_BIT_SW1];
    end

    // read word built field by field; unmapped positions stay zero
    always_comb begin
        rd_word = '0;
        rd_word[`SUPEN_BIT_LIMIT_SW] = req_vec[SUPEN_IDX_LIMIT];
        rd_word[`SUPEN_BIT_LREG4] = req_vec[SUPEN_IDX_LREG4];
        rd_word[`SUPEN_BIT_LREG3] = req_vec[SUPEN_IDX_LREG3];
        rd_word[`SUPEN_BIT_LREG2] = req_vec[SUPEN_IDX_LREG2];
        rd_word[`SUPEN_BIT_LREG1] = req_vec[SUPEN_IDX_LREG1];
        rd_word[`SUPEN_BIT_SW6] = req_vec[SUPEN_IDX_SW6];
        rd_word[`SUPEN_BIT_SW5] = req_vec[SUPEN_IDX_SW5];
        rd_word[`SUPEN_BIT_SW4] = req_vec[SUPEN_IDX_SW4];
        rd_word[`SUPEN_BIT_SW3] = req_vec[SUPEN_IDX_SW3];
        rd_word[`SUPEN_BIT_SW2] = req_vec[SUPEN_IDX_SW2];
        rd_word[`SUPEN_BIT_SW1] = req_vec[SUPEN_IDX_SW1];
    end

    // read port returns requests, not actual supply state
    always_comb begin
        rdata_nxt = rdata_r;
        rd_state_nxt = rd_state_r;
        if (reg_rd) begin
            rdata_nxt = hit ? (rd_word & IMPL) : 16'h0000;
        end
        unique case (rd_state_r)
            SUPEN_RD_IDLE: begin
                if (reg_rd) begin
                    rd_state_nxt = SUPEN_RD_ACK;
                end
            end
            SUPEN_RD_ACK: begin
                if (!reg_rd) begin
                    rd_state_nxt = SUPEN_RD_IDLE;
                end
            end
            default: begin
                rd_state_nxt = SUPEN_RD_IDLE;
            end
        endcase
    end

    // read port registers
    always_ff @(posedge clock) begin
        if (!rstn) begin
            rdata_r <= 16'h0000;
            rd_state_r <= SUPEN_RD_IDLE;
        end else if (ce) begin
            rdata_r <= rdata_nxt;
            rd_state_r <= rd_state_nxt;
        end
    end

    // request mirror, one edge behind the cells
    always_comb begin
        req_nxt = req_vec;
    end

    // mirror registers
    always_ff @(posedge clock) begin
        if (!rstn) begin
            req_r <= 11'h000;
        end else if (ce) begin
            req_r <= req_nxt;
        end
    end

    // supply enables: request gated by hold-off
    always_comb begin
        on_nxt = '0;
        for (int k = 0; k < NSUP; k++) begin
            if (req_vec[k] && !hold_off[k]) begin
                on_nxt[k] = 1'b1;
            end
        end
    end

    // supply enable registers
    always_ff @(posedge clock) begin
        if (!rstn) begin
            on_r <= 11'h000;
        end else if (ce) begin
            on_r <= on_nxt;
        end
    end

    // outputs come straight from registers
    assign reg_rdata = rdata_r;
    // the acknowledge is the one-hot bit of the ack state
    assign reg_rd_ack = rd_state_r[1];
    assign supply_on = on_r;
    assign limit_switch_on_request = req_r[SUPEN_IDX_LIMIT];
    assign linear_reg_four_on = req_r[SUPEN_IDX_LREG4];
    assign linear_reg_three_on = req_r[SUPEN_IDX_LREG3];
    assign linear_reg_two_on = req_r[SUPEN_IDX_LREG2];
    assign linear_reg_one_on = req_r[SUPEN_IDX_LREG1];
    assign switcher_six_on = req_r[SUPEN_IDX_SW6];
    assign switcher_five_on = req_r[SUPEN_IDX_SW5];
    assign switcher_four_on = req_r[SUPEN_IDX_SW4];
    assign switcher_three_on = req_r[SUPEN_IDX_SW3];
    assign switcher_two_on = req_r[SUPEN_IDX_SW2];
    assign switcher_one_on = req_r[SUPEN_IDX_SW1];

endmodule : supen_reg

`default_nettype wire

// ---- include/supen_params.svh ----
// constants for the supply output enable register
`ifndef SUPEN_PARAMS_SVH
`define SUPEN_PARAMS_SVH

`define SUPEN_ADDR_W 8
`define SUPEN_DATA_W 16
`define SUPEN_REG_ADDR 8'h0D
`define SUPEN_BIT_LIMIT_SW 15
`define SUPEN_BIT_LREG4 11
`define SUPEN_BIT_LREG3 10
`define SUPEN_BIT_LREG2 9
`define SUPEN_BIT_LREG1 8
`define SUPEN_BIT_SW6 5
`define SUPEN_BIT_SW5 4
`define SUPEN_BIT_SW4 3
`define SUPEN_BIT_SW3 2
`define SUPEN_BIT_SW2 1
`define SUPEN_BIT_SW1 0
`define SUPEN_IMPL_MASK 16'h8F3F
`define SUPEN_RESET_VAL 16'h0000
`define SUPEN_NUM_SUPPLIES 11

`endif

// ---- include/supen_pkg.sv ----
// types shared by the supply output enable register files
package supen_pkg;

    typedef logic [15:0] supen_word_t;
    typedef logic [7:0] supen_addr_t;
    typedef logic [10:0] supen_supply_t;

    // index of each supply in the packed supply vectors
    typedef enum logic [3:0] {
        SUPEN_IDX_SW1 = 4'h0,
        SUPEN_IDX_SW2 = 4'h1,
        SUPEN_IDX_SW3 = 4'h2,
        SUPEN_IDX_SW4 = 4'h3,
        SUPEN_IDX_SW5 = 4'h4,
        SUPEN_IDX_SW6 = 4'h5,
        SUPEN_IDX_LREG1 = 4'h6,
        SUPEN_IDX_LREG2 = 4'h7,
        SUPEN_IDX_LREG3 = 4'h8,
        SUPEN_IDX_LREG4 = 4'h9,
        SUPEN_IDX_LIMIT = 4'hA
    } supen_idx_t;

endpackage : supen_pkg

// ---- hdl/supen_req_cell.sv ----
// one request bit of the supply output enable register
`timescale 1ns/1ps
`default_nettype none

module supen_req_cell #(
    parameter bit IMPLEMENTED = 1'b1,
    parameter bit DEFAULT_VAL = 1'b0
) (
    input wire logic clock,
    input wire logic rstn,
    input wire logic ce,
    input wire logic restore,
    input wire logic wr,
    input wire logic wbit,
    output logic q
);

    logic bit_r;
    logic bit_nxt;

    // restore beats a write; unimplemented bits stay zero
    always_comb begin
        bit_nxt = bit_r;
        if (!IMPLEMENTED) begin
            bit_nxt = 1'b0;
        end else if (restore) begin
            bit_nxt = DEFAULT_VAL;
        end else if (wr) begin
            bit_nxt = wbit;
        end
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            bit_r <= IMPLEMENTED & DEFAULT_VAL;
        end else if (ce) begin
            bit_r <= bit_nxt;
        end
    end

    assign q = bit_r;

endmodule : supen_req_cell

`default_nettype wire

// ---- testbench/supen_reg_asserts.sv ----
// checker for the supply output enable register
`timescale 1ns/1ps
`default_nettype none
module supen_reg_asserts (
    input wire logic clock,
    input wire logic rstn,
    input wire logic ce,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_rd,
    input wire logic sm_restore,
    input wire logic [10:0] hold_off,
    input wire logic [15:0] reg_rdata,
    input wire logic reg_rd_ack,
    input wire logic limit_switch_on_request,
    input wire logic [10:0] supply_on
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rstn);
    wire logic wr_hit = ce && reg_wr && reg_addr == 8'h0D && !sm_restore;
    wire logic rd_hit = ce && reg_rd && reg_addr == 8'h0D && !reg_wr && !sm_restore;
    property p_ls; wr_hit ##1 rd_hit |=> limit_switch_on_request == $past(reg_wdata[15], 2);
    endproperty
    a_ls: assert property (p_ls) else $error("ls");
    property p_map; wr_hit ##1 rd_hit |=> reg_rdata == ($past(reg_wdata, 2) & 16'h8F3F);
    endproperty
    a_map: assert property (p_map) else $error("map");
    property p_off; $past(ce) |-> (supply_on & $past(hold_off)) == 11'h000; endproperty
    a_off: assert property (p_off) else $error("off");
    property p_rest; sm_restore && ce ##1 ce && !reg_wr |=> supply_on == 11'h000; endproperty
    a_rest: assert property (p_rest) else $error("rest");
    property p_dflt; sm_restore && ce ##1 rd_hit |=> reg_rdata == 16'h0000; endproperty
    a_dflt: assert property (p_dflt) else $error("dflt");
    property p_rst; !$past(rstn) |-> supply_on == 11'h000 && !reg_rd_ack; endproperty
    a_rst: assert property (p_rst) else $error("rst");
    property p_gap; reg_rd_ack |-> (reg_rdata & 16'h70C0) == 16'h0000; endproperty
    a_gap: assert property (p_gap) else $error("gap");
    property p_son; supply_on[10] |-> limit_switch_on_request; endproperty
    a_son: assert property (p_son) else $error("son");
endmodule : supen_reg_asserts
bind supen_reg supen_reg_asserts u_chk (.clock(clock), .rstn(rstn), .ce(ce),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
    .sm_restore(sm_restore), .hold_off(hold_off), .reg_rdata(reg_rdata),
    .reg_rd_ack(reg_rd_ack), .limit_switch_on_request(limit_switch_on_request),
    .supply_on(supply_on));
`default_nettype wire

// ---- testbench/supen_host.sv ----
// host and state machine model driving register accesses
`timescale 1ns/1ps
`default_nettype none
module supen_host (
    input wire logic clock,
    input wire logic [15:0] reg_rdata,
    input wire logic reg_rd_ack,
    output logic [7:0] reg_addr,
    output logic reg_wr,
    output logic reg_rd,
    output logic [15:0] reg_wdata,
    output logic sm_restore
);
    initial {reg_addr, reg_wr, reg_rd, reg_wdata, sm_restore} = '0;
    task put(input logic w, r, s, input logic [7:0] a, input logic [15:0] d);
        {reg_wr, reg_rd, sm_restore, reg_addr, reg_wdata} = {w, r, s, a, d};
        @(negedge clock);
    endtask : put
    // write then read back; released lines show the inverse
    task wrrd(input logic s, input logic [7:0] a, input logic [15:0] d, output logic [16:0] q);
        put(1'b1, 1'b0, s, a, d);
        put(1'b0, 1'b1, 1'b0, a, ~d);
        q = {reg_rd_ack, reg_rdata};
        put(1'b0, 1'b0, 1'b0, ~a, d);
    endtask : wrrd
endmodule : supen_host
`default_nettype wire

// ---- testbench/supen_reg_tb.sv ----
// testbench for the supply output enable register
`timescale 1ns/1ps
`default_nettype none
module supen_reg_tb;
    logic clock = 1'b0;
    logic rstn = 1'b0;
    logic [10:0] hold_off = 11'h000;
    logic ce = 1'b1;
    logic [16:0] q;
    int err_count = 0;
    int tests_run = 0;
    int pos [11] = '{0, 1, 2, 3, 4, 5, 8, 9, 10, 11, 15};
    wire logic [7:0] a;
    wire logic w, r, s, ack;
    wire logic [15:0] wd, rd;
    wire logic [10:0] req, son;
    always #25 clock = ~clock;
    supen_host u_host (.clock(clock), .reg_rdata(rd), .reg_rd_ack(ack), .reg_addr(a),
        .reg_wr(w), .reg_rd(r), .reg_wdata(wd), .sm_restore(s));
    supen_reg u_dut (.clock(clock), .rstn(rstn), .ce(ce), .reg_addr(a), .reg_wr(w),
        .reg_wdata(wd), .reg_rd(r), .sm_restore(s), .hold_off(hold_off), .reg_rdata(rd),
        .reg_rd_ack(ack), .limit_switch_on_request(req[10]), .linear_reg_four_on(req[9]),
        .linear_reg_three_on(req[8]), .linear_reg_two_on(req[7]), .linear_reg_one_on(req[6]),
        .switcher_six_on(req[5]), .switcher_five_on(req[4]), .switcher_four_on(req[3]),
        .switcher_three_on(req[2]), .switcher_two_on(req[1]), .switcher_one_on(req[0]),
        .supply_on(son));
    task chk(input string n, input logic [16:0] e, input logic [16:0] g);
        tests_run++;
        if (g !== e) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task tally_and_finish;
        $display("checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : tally_and_finish
    initial begin
        repeat (5) @(negedge clock);
        rstn = 1'b1;
        chk("req", 17'h00000, {6'h00, req});
        u_host.wrrd(1'b0, 8'h0E, 16'hFFFF, q);
        chk("rd", 17'h10000, q);
        chk("req", 17'h00000, {6'h00, req});
        for (int i = 0; i < 11; i++) begin
            u_host.wrrd(1'b0, 8'h0D, 16'h0001 << pos[i], q);
            chk("rd", 17'h10000 | (17'h00001 << pos[i]), q);
            chk("req", 17'h00001 << i, {6'h00, req});
        end
        u_host.wrrd(1'b0, 8'h0D, 16'hFFFF, q);
        chk("rd", 17'h18F3F, q);
        hold_off = 11'h555;
        @(negedge clock);
        chk("son", 17'h002AA, {6'h00, son});
        chk("req", 17'h007FF, {6'h00, req});
        u_host.wrrd(1'b0, 8'h0D, 16'hFFFF, q);
        chk("rd", 17'h18F3F, q);
        chk("son", 17'h002AA, {6'h00, son});
        ce = 1'b0;
        u_host.wrrd(1'b0, 8'h0D, 16'h0000, q);
        chk("rd", 17'h08F3F, q);
        chk("req", 17'h007FF, {6'h00, req});
        ce = 1'b1;
        rstn = 1'b0;
        repeat (2) @(negedge clock);
        rstn = 1'b1;
        chk("req", 17'h00000, {6'h00, req});
        chk("son", 17'h00000, {6'h00, son});
        u_host.wrrd(1'b0, 8'h0D, 16'h0020, q);
        chk("rd", 17'h10020, q);
        chk("req", 17'h00020, {6'h00, req});
        chk("son", 17'h00020, {6'h00, son});
        u_host.wrrd(1'b1, 8'h0D, 16'hFFFF, q);
        chk("rd", 17'h10000, q);
        chk("req", 17'h00000, {6'h00, req});
        tally_and_finish();
    end
endmodule : supen_reg_tb
`default_nettype wire
